// [verilog/twms_pkg.sv]
package twms_pkg;
  localparam logic [11:0] A_CTRL = 12'h000;
  localparam logic [11:0] A_STAT = 12'h004;
  localparam logic [11:0] A_DATA = 12'h008;
  localparam int B_FLAG = 7;
  localparam int B_ACK  = 6;
  localparam int B_BEG  = 5;
  localparam int B_HALT = 4;
  localparam int B_EN   = 2;
  localparam int B_IRQ  = 0;
  localparam logic [7:0] DATA_RST  = 8'hff;
  localparam logic [7:0] S_START   = 8'h08;
  localparam logic [7:0] S_RSTART  = 8'h10;
  localparam logic [7:0] S_AW_ACK  = 8'h18;
  localparam logic [7:0] S_AW_NAK  = 8'h20;
  localparam logic [7:0] S_TX_ACK  = 8'h28;
  localparam logic [7:0] S_TX_NAK  = 8'h30;
  localparam logic [7:0] S_LOST    = 8'h38;
  localparam logic [7:0] S_AR_ACK  = 8'h40;
  localparam logic [7:0] S_AR_NAK  = 8'h48;
  localparam logic [7:0] S_RX_ACK  = 8'h50;
  localparam logic [7:0] S_RX_NAK  = 8'h58;
  localparam logic [7:0] S_IDLE    = 8'hf8;
  localparam int CLK_MHZ      = 100;
  localparam int T_QUARTER_NS = 2500;
  localparam int Q_CYC = (T_QUARTER_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] Q_LAST = 8'(Q_CYC - 1);
  localparam logic [3:0] LAST_BIT = 4'h8;
  typedef enum logic [2:0] {
    E_IDLE, E_WFREE, E_START, E_BIT, E_STOP
  } twms_eng_e;
endpackage

// [verilog/twms_top.sv]
// Implementation choices: register access over APB and the address map.
`timescale 1ns/100ps
// How it works
// - Start request waits bus free, reports 0x08
// - Address direction bit picks send or receive
// - Writing one to done flag, with the enable bit also one, clears it
// - Read address: 0x40, 0x48 or 0x38
// - Sent byte reports 0x28 or 0x30
// - Clear with no requests sends next byte
// - Begin only gives repeated start, bus kept
// - Halt gives stop, then halt self-clears
// - Begin plus halt: stop then start
// - Lost arbitration reports 0x38, sets flag
// - After loss: release, or start when free
// - Received byte held in data register
// - Last wanted byte answered with not-ack
// - Repeated start reports 0x10
// - Status compares ignore prescaler bits
// - Interface runs only while enabled
// - Data write while flag low sets collision
// - Write address: 0x18, 0x20 or 0x38
// - Receive ack per ack enable: 0x50/0x58
module twms_top
  import twms_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        sys_rst_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_n_o,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n_o,
  output logic             irq_o
);
  ////////////////////////////////////////////////////////////
  twms_eng_e   eng_r, eng_nxt;
  logic        flag_r, flag_nxt, acken_r, acken_nxt;
  logic        beg_r, beg_nxt, halt_r, halt_nxt;
  logic        wcol_r, wcol_nxt, en_r, en_nxt;
  logic        irqen_r, irqen_nxt, pend_r, pend_nxt;
  logic [1:0]  pre_r, pre_nxt, ph_r, ph_nxt;
  logic [7:0]  data_r, data_nxt, status_r, status_nxt;
  logic [7:0]  sh_r, sh_nxt, qcnt_r, qcnt_nxt;
  logic [3:0]  bit_r, bit_nxt;
  logic        qtick_r, qtick_nxt, owned_r, owned_nxt;
  logic        addr_r, addr_nxt, rx_r, rx_nxt;
  logic        nak_r, nak_nxt, busy_r, busy_nxt;
  logic        sdaoe_r, sdaoe_nxt, scloe_r, scloe_nxt;
  logic        scl_m_r, scl_s_r, sda_m_r, sda_s_r, sda_d_r;
  logic [31:0] prdata_r, prdata_nxt;
  logic        pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic        irq_r, irq_nxt, lo_r;
  logic        obit, lsn, lost, bdone;
  logic [7:0]  ctl_rd;

  assign prdata_o   = prdata_r;
  assign pready_o   = pready_r;
  assign pslverr_o  = pslverr_r;
  assign scl_o      = lo_r;
  assign sda_o      = lo_r;
  assign scl_oe_n_o = scloe_r;
  assign sda_oe_n_o = sdaoe_r;
  assign irq_o      = irq_r;

  ////////////////////////////////////////////////////////////
  // Receive bytes listen, then drive the ack bit; address and sent bytes drive, then listen for ack
  always_comb begin
    lsn = (bit_r == LAST_BIT) ^ (rx_r & ~addr_r);
    if (bit_r == LAST_BIT) begin
      obit = (rx_r & ~addr_r) ? ~acken_r : 1'b1;
    end else begin
      obit = lsn ? 1'b1 : sh_r[7];
    end
    lost = eng_r == E_BIT && qtick_r && ph_r == 2'd2 && scl_s_r
           && ~lsn && obit && ~sda_s_r;
    bdone = eng_r == E_BIT && qtick_r && ph_r == 2'd3
            && bit_r == LAST_BIT;
    ctl_rd = {flag_r, acken_r, beg_r, halt_r, wcol_r, en_r,
              1'b0, irqen_r};
  end

  always_comb begin
    eng_nxt = eng_r;     flag_nxt = flag_r;   acken_nxt = acken_r;
    beg_nxt = beg_r;     halt_nxt = halt_r;   wcol_nxt = wcol_r;
    en_nxt = en_r;       irqen_nxt = irqen_r; pend_nxt = pend_r;
    pre_nxt = pre_r;     ph_nxt = ph_r;       data_nxt = data_r;
    status_nxt = status_r;                    sh_nxt = sh_r;
    bit_nxt = bit_r;     owned_nxt = owned_r; addr_nxt = addr_r;
    rx_nxt = rx_r;       nak_nxt = nak_r;     busy_nxt = busy_r;
    sdaoe_nxt = sdaoe_r; scloe_nxt = scloe_r;
    qtick_nxt = 1'b0;    qcnt_nxt = 8'h00;
    prdata_nxt = 32'h0;  pready_nxt = 1'b0;   pslverr_nxt = 1'b0;
    irq_nxt = flag_r & irqen_r;
    // Quarter-bit enable; idle costs no divider activity
    if (eng_r != E_IDLE) begin
      if (qcnt_r == Q_LAST) begin
        qtick_nxt = 1'b1;
      end else begin
        qcnt_nxt = qcnt_r + 8'h01;
      end
    end
    if (scl_s_r && sda_d_r && ~sda_s_r) begin
      busy_nxt = 1'b1;
    end else if (scl_s_r && ~sda_d_r && sda_s_r) begin
      busy_nxt = 1'b0;
    end
    // APB slave: one wait state, pready in second access cycle
    if (psel_i && penable_i && ~pready_r) begin
      pready_nxt = 1'b1;
      case (paddr_i)
        A_CTRL: begin
          if (pwrite_i) begin
            acken_nxt = pwdata_i[B_ACK];
            beg_nxt   = pwdata_i[B_BEG];
            halt_nxt  = pwdata_i[B_HALT];
            en_nxt    = pwdata_i[B_EN];
            irqen_nxt = pwdata_i[B_IRQ];
            if (pwdata_i[B_FLAG] && pwdata_i[B_EN] && flag_r) begin
              flag_nxt = 1'b0;
              pend_nxt = 1'b1;
            end else if (pwdata_i[B_FLAG] && pwdata_i[B_EN]
                         && pwdata_i[B_BEG] && eng_r == E_IDLE
                         && ~owned_r) begin
              pend_nxt = 1'b1;
            end
          end else begin
            prdata_nxt = {24'h0, ctl_rd};
          end
        end
        A_STAT: begin
          if (pwrite_i) begin
            pre_nxt = pwdata_i[1:0];
          end else begin
            prdata_nxt = {24'h0, status_r[7:3], 1'b0, pre_r};
          end
        end
        A_DATA: begin
          if (pwrite_i) begin
            if (flag_r) begin
              data_nxt = pwdata_i[7:0];
              wcol_nxt = 1'b0;
            end else begin
              wcol_nxt = 1'b1;
            end
          end else begin
            prdata_nxt = {24'h0, data_r};
          end
        end
        default: pslverr_nxt = 1'b1;
      endcase
    end
    ////////////////////////////////////////////////////////////
    // Engine; its flag set comes last so it beats a clear
    if (~en_r) begin
      eng_nxt = E_IDLE;
      sdaoe_nxt = 1'b1;
      scloe_nxt = 1'b1;
      owned_nxt = 1'b0;
      pend_nxt = pend_nxt & en_nxt; // Keeps a start sent with enable
      ph_nxt = 2'd0;
    end else begin
      unique case (eng_r)
        E_IDLE: begin
          if (pend_r) begin
            pend_nxt = 1'b0;
            ph_nxt = 2'd0;
            bit_nxt = 4'h0;
            if (halt_r && owned_r) begin
              eng_nxt = E_STOP;
            end else if (beg_r) begin
              eng_nxt = owned_r ? E_START : E_WFREE;
            end else if (owned_r) begin
              eng_nxt = E_BIT;
              sh_nxt = data_r;
            end else begin
              halt_nxt = 1'b0;
              sdaoe_nxt = 1'b1;
              scloe_nxt = 1'b1;
              status_nxt = S_IDLE;
            end
          end
        end
        E_WFREE: begin
          if (~busy_r) begin
            eng_nxt = E_START;
          end
        end
        E_START: begin
          if (qtick_r) begin
            unique case (ph_r)
              2'd0: begin sdaoe_nxt = 1'b1; ph_nxt = 2'd1; end
              2'd1: begin scloe_nxt = 1'b1; ph_nxt = 2'd2; end
              2'd2: begin
                if (scl_s_r) begin
                  sdaoe_nxt = 1'b0;
                  ph_nxt = 2'd3;
                end
              end
              2'd3: begin
                scloe_nxt = 1'b0;
                ph_nxt = 2'd0;
                eng_nxt = E_IDLE;
                flag_nxt = 1'b1;
                status_nxt = owned_r ? S_RSTART : S_START;
                owned_nxt = 1'b1;
                addr_nxt = 1'b1;
                rx_nxt = 1'b0;
              end
            endcase
          end
        end
        E_BIT: begin
          if (lost) begin
            eng_nxt = E_IDLE;
            sdaoe_nxt = 1'b1;
            scloe_nxt = 1'b1;
            owned_nxt = 1'b0;
            addr_nxt = 1'b0;
            flag_nxt = 1'b1;
            status_nxt = S_LOST;
            ph_nxt = 2'd0;
          end else if (qtick_r) begin
            unique case (ph_r)
              2'd0: begin sdaoe_nxt = obit; ph_nxt = 2'd1; end
              2'd1: begin scloe_nxt = 1'b1; ph_nxt = 2'd2; end
              2'd2: begin
                // Clock stretching by the far end holds this phase
                if (scl_s_r) begin
                  if (bit_r == LAST_BIT) begin
                    nak_nxt = sda_s_r;
                  end else begin
                    sh_nxt = {sh_r[6:0], sda_s_r};
                  end
                  ph_nxt = 2'd3;
                end
              end
              2'd3: begin
                scloe_nxt = 1'b0;
                ph_nxt = 2'd0;
                if (bit_r != LAST_BIT) begin
                  bit_nxt = bit_r + 4'h1;
                end else begin
                  sdaoe_nxt = 1'b1;
                  eng_nxt = E_IDLE;
                  flag_nxt = 1'b1;
                  if (addr_r) begin
                    addr_nxt = 1'b0;
                    rx_nxt = data_r[0];
                    if (data_r[0]) begin
                      status_nxt = nak_r ? S_AR_NAK : S_AR_ACK;
                    end else begin
                      status_nxt = nak_r ? S_AW_NAK : S_AW_ACK;
                    end
                  end else if (rx_r) begin
                    data_nxt = sh_r;
                    status_nxt = acken_r ? S_RX_ACK : S_RX_NAK;
                  end else begin
                    status_nxt = nak_r ? S_TX_NAK : S_TX_ACK;
                  end
                end
              end
            endcase
          end
        end
        E_STOP: begin
          if (qtick_r) begin
            unique case (ph_r)
              2'd0: begin sdaoe_nxt = 1'b0; ph_nxt = 2'd1; end
              2'd1: begin scloe_nxt = 1'b1; ph_nxt = 2'd2; end
              2'd2: begin
                if (scl_s_r) begin
                  sdaoe_nxt = 1'b1;
                  ph_nxt = 2'd3;
                end
              end
              2'd3: begin
                halt_nxt = 1'b0;
                owned_nxt = 1'b0;
                ph_nxt = 2'd0;
                status_nxt = S_IDLE;
                eng_nxt = beg_r ? E_WFREE : E_IDLE;
              end
            endcase
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////
  always_ff @(posedge clock_i) begin
    scl_m_r <= scl_i;
    scl_s_r <= scl_m_r;
    sda_m_r <= sda_i;
    sda_s_r <= sda_m_r;
    sda_d_r <= sda_s_r;
    lo_r    <= 1'b0;
    if (sys_rst_i) begin
      eng_r <= E_IDLE;
      {flag_r, acken_r, beg_r, halt_r, wcol_r, en_r} <= 6'h00;
      {irqen_r, pend_r, qtick_r, owned_r, addr_r, rx_r} <= 6'h00;
      {nak_r, busy_r, pready_r, pslverr_r, irq_r} <= 5'h00;
      {sdaoe_r, scloe_r} <= 2'h3;
      {pre_r, ph_r, bit_r} <= 8'h00;
      {sh_r, qcnt_r} <= 16'h0000;
      data_r <= DATA_RST;
      status_r <= S_IDLE;
      prdata_r <= 32'h0;
    end else begin
      eng_r <= eng_nxt;     flag_r <= flag_nxt;   acken_r <= acken_nxt;
      beg_r <= beg_nxt;     halt_r <= halt_nxt;   wcol_r <= wcol_nxt;
      en_r <= en_nxt;       irqen_r <= irqen_nxt; pend_r <= pend_nxt;
      qtick_r <= qtick_nxt; owned_r <= owned_nxt; addr_r <= addr_nxt;
      rx_r <= rx_nxt;       nak_r <= nak_nxt;     busy_r <= busy_nxt;
      pready_r <= pready_nxt;                     irq_r <= irq_nxt;
      pslverr_r <= pslverr_nxt;                   prdata_r <= prdata_nxt;
      sdaoe_r <= sdaoe_nxt; scloe_r <= scloe_nxt; pre_r <= pre_nxt;
      ph_r <= ph_nxt;       bit_r <= bit_nxt;     sh_r <= sh_nxt;
      qcnt_r <= qcnt_nxt;   data_r <= data_nxt;   status_r <= status_nxt;
    end
  end

  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  flag_clear_a: assert property (pready_r && psel_i && pwrite_i
      && paddr_i == A_CTRL && $past(flag_r) && $past(pwdata_i[B_FLAG])
      && $past(pwdata_i[B_EN]) |-> !flag_r)
    else $error("done flag not cleared");
  wr_coll_a: assert property (psel_i && penable_i && !pready_r
      && pwrite_i && paddr_i == A_DATA && !flag_r
      |=> wcol_r && $stable(data_r))
    else $error("collision write not refused");
  irq_req_a: assert property (flag_r && irqen_r |=> irq_o)
    else $error("irq missing");
  rstart_code_a: assert property (eng_r == E_START && qtick_r
      && ph_r == 2'd3 && owned_r |=> status_r == S_RSTART && flag_r)
    else $error("repeated start status wrong");
  arb_lost_a: assert property (lost |=>
      flag_r && status_r == S_LOST && sda_oe_n_o && scl_oe_n_o)
    else $error("arbitration loss not reported");
  rx_byte_a: assert property (bdone && rx_r && !addr_r
      |=> data_r == $past(sh_r) && flag_r)
    else $error("received byte not stored");
  halt_self_a: assert property (eng_r == E_STOP && qtick_r
      && ph_r == 2'd3 |=> !halt_r && !owned_r)
    else $error("halt not cleared after stop");
  disable_rel_a: assert property (!en_r |=>
      sda_oe_n_o && scl_oe_n_o && eng_r == E_IDLE)
    else $error("bus not released while disabled");
  tx_code_a: assert property (bdone && !rx_r && !addr_r
      |=> status_r == ($past(nak_r) ? S_TX_NAK : S_TX_ACK))
    else $error("sent byte status wrong");
  ar_code_a: assert property (bdone && addr_r && data_r[0]
      |=> rx_r && status_r == ($past(nak_r) ? S_AR_NAK : S_AR_ACK))
    else $error("read address status wrong");

  start_c: cover property (eng_r == E_START ##1 status_r == S_START);
  rx_c: cover property (bdone && rx_r && !addr_r);
  stop_c: cover property (eng_r == E_STOP ##1 eng_r == E_WFREE);
  lost_c: cover property (lost);
endmodule

// [verif/twms_peer.sv]
`timescale 1ns/100ps
// Far side of the bus: one addressed target plus a rival controller
module twms_peer #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic       nak_i,
  input  wire logic       lose_i,
  input  wire logic       slow_i,
  input  wire logic [7:0] tx_i,
  output logic            scl_oe_n_o,
  output logic            sda_oe_n_o,
  output logic      [7:0] rx_o,
  output logic            mack_o
);
  logic [7:0] sr = 8'h00;
  int         cnt = 0;
  logic       act = 1'b0;
  logic       first = 1'b0;
  logic       rd = 1'b0;
  initial begin
    scl_oe_n_o = 1'b1;
    sda_oe_n_o = 1'b1;
    rx_o = 8'h00;
    mack_o = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////
  always @(negedge sda_i) if (scl_i) begin
    act = 1'b1;
    first = 1'b1;
    rd = 1'b0;
    cnt = 0;
  end
  always @(posedge sda_i) if (scl_i) act = 1'b0;
  // Rival pulls data low while the clock is held low
  always @(posedge lose_i) sda_oe_n_o = 1'b0;
  // Reply byte may be loaded late, while the clock is still held low
  always @(tx_i) if (act && rd && !first && cnt == 0 && !scl_i)
    sda_oe_n_o = tx_i[7];
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge scl_i) if (act) begin
    sr = {sr[6:0], sda_i};
    cnt++;
    if (cnt == 8) rx_o = sr;
    if (cnt == 9) mack_o = sda_i;
    if (lose_i) begin
      // Held past the sample point so the clash is seen
      #3000 sda_oe_n_o = 1'b1;
      act = 1'b0;
    end
  end
  always @(negedge scl_i) if (act) begin
    sda_oe_n_o = 1'b1;
    if (cnt == 9) begin
      cnt = 0;
      first = 1'b0;
      if (sr[0]) rd = 1'b0;
    end
    if (cnt == 8) begin
      sda_oe_n_o = rd | (first ? sr[7:1] != ADDR : nak_i);
      if (first) rd = sr[0] & (sr[7:1] == ADDR);
      if (slow_i) begin
        scl_oe_n_o = 1'b0;
        #9000 scl_oe_n_o = 1'b1;
      end
    end else if (rd && !first) sda_oe_n_o = tx_i[7 - cnt];
  end
endmodule

// [verif/twms_bench.sv]
`timescale 1ns/100ps
module twms_bench;
  import twms_pkg::*;
  localparam logic [6:0] ADDR = 7'h2a;
  logic        clock_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic        pready, pslverr, err, scl_o, sda_o, scl_oe_n, sda_oe_n;
  logic        irq, m_scl, m_sda, mack;
  logic        nak = 1'b0, lose = 1'b0, slow = 1'b0;
  logic [7:0]  tx = 8'h00, rx;
  logic [15:0] lf = 16'hb7e5;
  int          fail_count = 0, num_checks = 0;
  wire         scl_w = (scl_oe_n !== 1'b0) && m_scl;
  wire         sda_w = (sda_oe_n !== 1'b0) && m_sda;
  always #5 clock_i = ~clock_i;
  ////////////////////////////////////////////////////////////////////////////
  twms_top i_dut (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .paddr_i(paddr),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .scl_i(scl_w), .scl_o(scl_o),
    .scl_oe_n_o(scl_oe_n), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n), .irq_o(irq));
  twms_peer #(.ADDR(ADDR)) i_peer (
    .scl_i(scl_w), .sda_i(sda_w), .nak_i(nak), .lose_i(lose),
    .slow_i(slow), .tx_i(tx), .scl_oe_n_o(m_scl), .sda_oe_n_o(m_sda),
    .rx_o(rx), .mack_o(mack));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic report_and_stop();
    if (fail_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Called right after a rising edge; request held until pready is seen
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    repeat (20) begin
      @(posedge clock_i);
      if (pready === 1'b1) break;
    end
    if (pready !== 1'b1) begin
      fail_count++;
      report_and_stop();
    end
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic go(input logic [7:0] c);
    apb(1'b1, A_CTRL, {24'h0, c});
    apb(1'b0, A_CTRL, 32'h0);
    chk(rv[B_FLAG], 1'b0);
  endtask
  // Polling is bounded; a byte on the wire is about 9000 cycles
  task automatic wait_flag(input logic [7:0] st);
    repeat (400) begin
      apb(1'b0, A_CTRL, 32'h0);
      if (rv[B_FLAG] === 1'b1) break;
      repeat (50) @(posedge clock_i);
    end
    if (rv[B_FLAG] !== 1'b1) begin
      fail_count++;
      report_and_stop();
    end
    apb(1'b0, A_STAT, 32'h0);
    chk(rv & 32'hf8, {24'h0, st});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    apb(1'b0, A_CTRL, 32'h0);
    chk(rv, 32'h0);
    apb(1'b0, A_STAT, 32'h0);
    chk(rv, 32'hf8);
    apb(1'b0, 12'h00c, 32'h0);
    chk(err, 1'b1);
    lf = lfsr(lf);
    apb(1'b1, A_STAT, {30'h0, lf[1:0]});
    apb(1'b1, A_DATA, 32'h5a);
    apb(1'b0, A_DATA, 32'h0);
    chk(rv, 32'hff);
    apb(1'b0, A_CTRL, 32'h0);
    chk(rv[3], 1'b1);
    go(8'ha5);
    wait_flag(S_START);
    repeat (3) @(posedge clock_i);
    chk({irq, scl_w, scl_o, sda_o}, 4'h8);
    apb(1'b1, A_DATA, {24'h0, ADDR, 1'b0});
    go(8'h85);
    wait_flag(S_AW_ACK);
    for (int i = 0; i < 2; i++) begin
      lf = lfsr(lf);
      nak <= i[0];
      apb(1'b1, A_DATA, {24'h0, lf[7:0]});
      go(i[0] ? 8'h84 : 8'h85);
      wait_flag(i[0] ? S_TX_NAK : S_TX_ACK);
      chk(rx, lf[7:0]);
    end
    repeat (3) @(posedge clock_i);
    chk(irq, 1'b0);
    go(8'ha4);
    wait_flag(S_RSTART);
    apb(1'b1, A_DATA, {24'h0, ADDR, 1'b1});
    go(8'h84);
    wait_flag(S_AR_ACK);
    for (int i = 0; i < 2; i++) begin
      lf = lfsr(lf);
      tx <= lf[7:0];
      slow <= !i[0];
      go(i[0] ? 8'h84 : 8'hc4);
      wait_flag(i[0] ? S_RX_NAK : S_RX_ACK);
      chk(mack, i[0]);
      apb(1'b0, A_DATA, 32'h0);
      chk(rv, {24'h0, lf[7:0]});
    end
    slow <= 1'b0;
    go(8'hb4);
    wait_flag(S_START);
    apb(1'b0, A_CTRL, 32'h0);
    chk(rv[B_HALT], 1'b0);
    lose <= 1'b1;
    apb(1'b1, A_DATA, 32'hff);
    go(8'h84);
    wait_flag(S_LOST);
    lose <= 1'b0;
    go(8'h84);
    repeat (10) @(posedge clock_i);
    apb(1'b0, A_STAT, 32'h0);
    chk({rv[7:3], scl_oe_n, sda_oe_n}, 7'h7f);
    go(8'ha4);
    wait_flag(S_START);
    go(8'h94);
    repeat (100) begin
      apb(1'b0, A_CTRL, 32'h0);
      if (rv[B_HALT] === 1'b0) break;
      repeat (50) @(posedge clock_i);
    end
    chk(rv[B_HALT], 1'b0);
    repeat (300) @(posedge clock_i);
    chk({scl_w, sda_w}, 2'b11);
    apb(1'b1, A_CTRL, 32'ha0);
    repeat (1500) @(posedge clock_i);
    chk({scl_oe_n, sda_oe_n}, 2'b11);
    report_and_stop();
  end
endmodule
